// file: mispr_checker.sv
// Checker for the interrupt status and priority block: bus timing and core handshake.
// Assumes it is bound to mispr_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module mispr_checker #(
    parameter int NUM_SRC = 32
) (
    input wire logic               ref_clk,
    input wire logic               rst_b,
    input wire logic               hsel,
    input wire logic [1:0]         htrans,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic [NUM_SRC-1:0] irqReq,
    input wire logic               nmiReq,
    input wire logic               coreGlobalEn,
    input wire logic               coreAck,
    input wire logic               coreIrq,
    input wire logic               coreNmi,
    input wire logic [7:0]         ackVector
);
    // Sources 0 and 19 have no request behind them
    localparam logic [NUM_SRC-1:0] LIVE = NUM_SRC'(32'hfff7_fffe);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // Register bus
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not OKAY");
    a_one_wait: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
        else $error("bus wait state missing");
    a_wait_short: assert property (!hreadyout |=> hreadyout)
        else $error("bus wait longer than one cycle");
    // ==========================================================
    // Core handshake; a stale request would show up two edges late
    a_vec_range: assert property (coreAck |=> ackVector inside {[8'h10:8'h2f]})
        else $error("acknowledged vector out of range");
    a_vec_hold: assert property (!coreAck |=> $stable(ackVector))
        else $error("vector changed without acknowledge");
    a_irq_cause: assert property (coreIrq |-> |($past(irqReq, 2) & LIVE))
        else $error("core request without live source");
    a_irq_global: assert property (!coreGlobalEn |=> !coreIrq)
        else $error("core request while globally disabled");
    a_ack_drop: assert property (coreAck |=> !coreIrq)
        else $error("core request not dropped on acknowledge");
    a_nmi_pass: assert property (1'b1 |=> coreNmi == $past(nmiReq))
        else $error("non-maskable request not passed");
    c_ack: cover property (coreAck);
    c_nested: cover property (coreAck ##[1:60] coreAck);
    c_blocked: cover property (!coreGlobalEn && |irqReq);
endmodule
bind mispr_top mispr_checker #(.NUM_SRC(NUM_SRC)) u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .irqReq(irqReq), .nmiReq(nmiReq),
    .coreGlobalEn(coreGlobalEn), .coreAck(coreAck), .coreIrq(coreIrq),
    .coreNmi(coreNmi), .ackVector(ackVector)
);
`default_nettype wire

// file: mispr_core_model.sv
// Behavioural core that takes vectored maskable requests.
// Assumes coreIrq is a registered level; acks only when ackGo allows it.
`timescale 1ns/1ps
`default_nettype none
module mispr_core_model (
    input wire logic  ref_clk,
    input wire logic  rst_b,
    input wire logic  coreIrq,
    input wire logic  ackGo,
    input wire logic  slow,
    input wire logic  reEn,
    output logic      coreGlobalEn,
    output logic      coreAck
);
    logic [1:0] waitQ;
    // ==========================================================
    // Entry drops the global enable; a handler re-sets it to nest
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            coreGlobalEn <= 1'b1;
            coreAck      <= 1'b0;
            waitQ        <= 2'h0;
        end else begin
            coreAck <= 1'b0;
            if (coreAck) begin
                coreGlobalEn <= 1'b0;
            end else if (reEn) begin
                coreGlobalEn <= 1'b1;
            end
            // Slow mode lets the request stand a few cycles before entry
            if (ackGo && coreIrq && coreGlobalEn && !coreAck) begin
                waitQ <= waitQ + 2'h1;
                if (!slow || waitQ == 2'h3) begin
                    coreAck <= 1'b1;
                    waitQ   <= 2'h0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: mispr_pkg.sv
// Constants, types and register map of the maskable interrupt status and priority block.
// Assumes a single 200 MHz clock and an AHB-Lite register bus of 32-bit words.
// Summary of operation
// - A read-only 16-bit status word shows the request state of sources 1 to 15.
// - Status bits show the raw requests whatever the per-source enables say.
// - Lower status word bits 15 down to 1 show sources 15 down to 1.
// - Bit 0 of the lower status word always reads zero.
// - Upper status word bits 15 down to 0 show sources 31 down to 16; bit 3 (reserved source 19) always reads zero.
// - Among active enabled requests, the highest source number wins; 31 is highest.
// - Upper sources: timer 0, radio link 0-5, USB, DMA 0-3, reserved, audio, UART rx, transcoder.
// - Lower sources: two-wire, timers A/B, versatile timer 1-4, SPI, UART, wakeups, flash.
// - Non-maskable requests always pass to the core, even inside a handler.
// - After an acknowledge no maskable request is offered until global enable is set again.
// - No limit on nesting depth is imposed by this logic.
// - The vector reads 10h plus the winning source number, from 10h to 2Fh.
// - Two 16-bit enable words reset to all ones; disabled sources never win.
package mispr_pkg;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_VECTOR      = 8'h00;
    localparam logic [7:0]  IDX_STATUS_LOW  = 8'h0a;
    localparam logic [7:0]  IDX_STATUS_HIGH = 8'h0c;
    localparam logic [7:0]  IDX_ENABLE_LOW  = 8'h0e;
    localparam logic [7:0]  IDX_ENABLE_HIGH = 8'h10;
    localparam logic [7:0]  IDX_EVT_STATUS  = 8'h14;
    localparam logic [7:0]  IDX_EVT_MASK    = 8'h16;
    localparam int          ADDR_WIDTH      = 10;

    // ==========================================================
    // Reset values and field layout
    localparam logic [15:0] ENABLE_RESET    = 16'hffff;
    localparam logic [1:0]  EVT_MASK_RESET  = 2'h0;
    localparam logic [5:0]  VECTOR_BASE     = 6'h10;
    localparam int          EVT_ACK_BIT     = 0;
    localparam int          EVT_SPUR_BIT    = 1;
    localparam int          EVT_WIDTH       = 2;
    localparam int          NUM_SOURCES     = 32;

    // ==========================================================
    // Source assignment
    localparam int SRC_TIMER0     = 31;
    localparam int SRC_RADIO0     = 30;
    localparam int SRC_RADIO5     = 25;
    localparam int SRC_USB        = 24;
    localparam int SRC_DMA0       = 23;
    localparam int SRC_DMA3       = 20;
    localparam int SRC_RESERVED19 = 19;
    localparam int SRC_AUDIO      = 18;
    localparam int SRC_UART_RX    = 17;
    localparam int SRC_TRANSCODER = 16;
    localparam int SRC_TWO_WIRE   = 15;
    localparam int SRC_TIMER_A    = 14;
    localparam int SRC_TIMER_B    = 13;
    localparam int SRC_VTIMER1    = 12;
    localparam int SRC_VTIMER4    = 9;
    localparam int SRC_SPI        = 8;
    localparam int SRC_UART_TX    = 7;
    localparam int SRC_UART_CTS   = 6;
    localparam int SRC_WAKEUP0    = 5;
    localparam int SRC_WAKEUP3    = 2;
    localparam int SRC_FLASH      = 1;
    localparam int SRC_RESERVED0  = 0;

    // ==========================================================
    // AHB address phase held for its data phase
    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic [ADDR_WIDTH-1:0] addr;
    } mispr_addr_s;

    typedef enum logic [1:0] {
        HTRANS_IDLE   = 2'h0,
        HTRANS_BUSY   = 2'h1,
        HTRANS_NONSEQ = 2'h2,
        HTRANS_SEQ    = 2'h3
    } mispr_htrans_e;

endpackage

// file: mispr_prio_enc.sv
// Fixed linear priority encoder: the highest set input bit wins.
// Assumes a purely combinational use; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module mispr_prio_enc #(
    parameter int N = 32,
    parameter int W = 5
) (
    input  wire logic [N-1:0] pend,
    output logic      [W-1:0] index,
    output logic              found
);

    logic [N:0]       higherSet;
    logic [N-1:0][W-1:0] pick;

    // Chain from the top down; each bit wins only if nothing above it is set
    assign higherSet[N] = 1'b0;
    generate
        for (genvar i = 0; i < N; i++) begin : g_chain
            assign higherSet[i] = higherSet[i+1] | pend[i];
            assign pick[i]      = (pend[i] && !higherSet[i+1]) ? W'(i) : '0;
        end
    endgenerate

    // Only one pick is non-zero, so an OR tree merges them
    always_comb begin
        index = '0;
        for (int k = 0; k < N; k++) begin
            index = index | pick[k];
        end
    end

    assign found = higherSet[0];

endmodule
`default_nettype wire

// file: mispr_top.sv
// Maskable interrupt status and priority unit with AHB-Lite register access.
// Assumes level requests synchronous to ref_clk and a core that pulses coreAck on entry.
`timescale 1ns/1ps
`default_nettype none
module mispr_top #(
    parameter int NUM_SRC = mispr_pkg::NUM_SOURCES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Peripheral requests and core side
    input  wire logic [NUM_SRC-1:0] irqReq,
    input  wire logic        nmiReq,
    input  wire logic        coreGlobalEn,
    input  wire logic        coreAck,
    output logic             coreIrq,
    output logic             coreNmi,
    output logic      [7:0]  ackVector,
    output logic             irqOut
);

    // ==========================================================
    // Source conditioning
    localparam logic [NUM_SRC-1:0] RESERVED_MASK =
        (NUM_SRC'(1) << mispr_pkg::SRC_RESERVED0) | (NUM_SRC'(1) << mispr_pkg::SRC_RESERVED19);

    logic [NUM_SRC-1:0] reqClean;
    logic [NUM_SRC-1:0] status_q;
    logic [NUM_SRC-1:0] status_d;

    // Unconnected inputs are forced low so a stray tie never reports
    assign reqClean = irqReq & ~RESERVED_MASK;
    // Level sampling only; a dropped request clears next cycle
    assign status_d = reqClean;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    // ==========================================================
    // Enables and priority
    logic [15:0]        enLow_q;
    logic [15:0]        enHigh_q;
    logic [NUM_SRC-1:0] enableAll;
    logic [NUM_SRC-1:0] pending;
    logic [4:0]         winIdx;
    logic               winFound;
    logic [5:0]         vectorNow;

    // Enable bit 0 of the lower word is kept but never used
    assign enableAll = {enHigh_q, enLow_q[15:1], 1'b0};
    assign pending   = status_q & enableAll;

    mispr_prio_enc #(
        .N (NUM_SRC),
        .W (5)
    ) u_prio (
        .pend  (pending),
        .index (winIdx),
        .found (winFound)
    );

    // With nothing pending the vector falls to 10h, the error entry
    assign vectorNow = mispr_pkg::VECTOR_BASE + {1'b0, winIdx};

    // ==========================================================
    // Bus address decode
    mispr_pkg::mispr_addr_s aph_q;
    logic                   takeAddr;
    logic [7:0]             regIdx;
    logic                   wordAligned;
    logic                   selVector;
    logic                   selStatLow;
    logic                   selStatHigh;
    logic                   selEnLow;
    logic                   selEnHigh;
    logic                   selEvtStat;
    logic                   selEvtMask;
    logic                   doWrite;
    logic [31:0]            readMux;

    assign takeAddr    = hsel && hready && htrans[1];
    assign regIdx      = aph_q.addr[9:2];
    assign wordAligned = (aph_q.addr[1:0] == 2'h0);
    assign selVector   = wordAligned && (regIdx == mispr_pkg::IDX_VECTOR);
    assign selStatLow  = wordAligned && (regIdx == mispr_pkg::IDX_STATUS_LOW);
    assign selStatHigh = wordAligned && (regIdx == mispr_pkg::IDX_STATUS_HIGH);
    assign selEnLow    = wordAligned && (regIdx == mispr_pkg::IDX_ENABLE_LOW);
    assign selEnHigh   = wordAligned && (regIdx == mispr_pkg::IDX_ENABLE_HIGH);
    assign selEvtStat  = wordAligned && (regIdx == mispr_pkg::IDX_EVT_STATUS);
    assign selEvtMask  = wordAligned && (regIdx == mispr_pkg::IDX_EVT_MASK);
    // Writes act in the wait cycle, when hwdata is already on the bus
    assign doWrite     = aph_q.valid && aph_q.write;

    // Address phase capture; one wait state lets hrdata come from a flop
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            aph_q <= '0;
        end else if (takeAddr) begin
            aph_q <= '{valid: 1'b1, write: hwrite, addr: haddr[mispr_pkg::ADDR_WIDTH-1:0]};
        end else begin
            aph_q.valid <= 1'b0;
        end
    end

    // ==========================================================
    // Enable registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            enLow_q  <= mispr_pkg::ENABLE_RESET;
            enHigh_q <= mispr_pkg::ENABLE_RESET;
        end else if (doWrite) begin
            if (selEnLow) begin
                enLow_q <= hwdata[15:0];
            end
            if (selEnHigh) begin
                enHigh_q <= hwdata[15:0];
            end
        end
    end

    // ==========================================================
    // Core handshake
    logic ackBlock_q;
    logic ackBlock_d;
    logic globalEnPrev_q;
    logic globalEnRise;
    logic coreIrq_d;

    // Blocked from acknowledge until software sets global enable again
    assign globalEnRise = coreGlobalEn && !globalEnPrev_q;
    assign ackBlock_d   = coreAck ? 1'b1 : (globalEnRise ? 1'b0 : ackBlock_q);
    assign coreIrq_d    = winFound && coreGlobalEn && !ackBlock_d;

    // No depth counter exists; each level is just another acknowledge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ackBlock_q     <= 1'b0;
            globalEnPrev_q <= 1'b0;
            coreIrq        <= 1'b0;
            ackVector      <= 8'h00;
        end else begin
            ackBlock_q     <= ackBlock_d;
            globalEnPrev_q <= coreGlobalEn;
            coreIrq        <= coreIrq_d;
            if (coreAck) begin
                ackVector <= {2'h0, vectorNow};
            end
        end
    end

    // Non-maskable path ignores every mask and the acknowledge block
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            coreNmi <= 1'b0;
        end else begin
            coreNmi <= nmiReq;
        end
    end

    // ==========================================================
    // Event status, mask and interrupt line
    logic [mispr_pkg::EVT_WIDTH-1:0] evtStat_q;
    logic [mispr_pkg::EVT_WIDTH-1:0] evtStat_d;
    logic [mispr_pkg::EVT_WIDTH-1:0] evtMask_q;
    logic [mispr_pkg::EVT_WIDTH-1:0] evtSet;
    logic [mispr_pkg::EVT_WIDTH-1:0] evtClr;

    // Spurious acknowledge means the vector would read the error entry
    assign evtSet[mispr_pkg::EVT_ACK_BIT]  = coreAck;
    assign evtSet[mispr_pkg::EVT_SPUR_BIT] = coreAck && !winFound;
    assign evtClr    = (doWrite && selEvtStat) ? hwdata[mispr_pkg::EVT_WIDTH-1:0] : '0;
    // Set wins so an event in the clearing cycle survives
    assign evtStat_d = (evtStat_q & ~evtClr) | evtSet;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            evtStat_q <= '0;
            evtMask_q <= mispr_pkg::EVT_MASK_RESET;
            irqOut    <= 1'b0;
        end else begin
            evtStat_q <= evtStat_d;
            if (doWrite && selEvtMask) begin
                evtMask_q <= hwdata[mispr_pkg::EVT_WIDTH-1:0];
            end
            irqOut <= |(evtStat_q & evtMask_q);
        end
    end

    // ==========================================================
    // Read data
    logic [15:0] statusLowWord;
    logic [15:0] statusHighWord;

    assign statusLowWord  = {status_q[15:1], 1'b0};
    assign statusHighWord = status_q[31:16];

    // Unmapped or unaligned addresses read zero
    assign readMux = selVector   ? {24'h0, 2'h0, vectorNow} :
                     selStatLow  ? {16'h0, statusLowWord} :
                     selStatHigh ? {16'h0, statusHighWord} :
                     selEnLow    ? {16'h0, enLow_q} :
                     selEnHigh   ? {16'h0, enHigh_q} :
                     selEvtStat  ? {30'h0, evtStat_q} :
                     selEvtMask  ? {30'h0, evtMask_q} :
                                   32'h0;

    // Ready drops for the one wait cycle after each accepted address
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (takeAddr) begin
                hreadyout <= 1'b0;
            end else if (aph_q.valid) begin
                hreadyout <= 1'b1;
                hrdata    <= aph_q.write ? 32'h0 : readMux;
            end
        end
    end

endmodule
`default_nettype wire

// file: mispr_top_tb.sv
// Self-checking bench for the interrupt status and priority block.
// Assumes the core model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module mispr_top_tb;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] irqReq = 32'h0;
    logic        nmiReq = 1'b0;
    logic        ackGo = 1'b0;
    logic        slow = 1'b0;
    logic        reEn = 1'b0;
    logic [31:0] hrdata, rdv;
    logic [7:0]  ackVector;
    logic        hreadyout, hresp, coreGlobalEn, coreAck, coreIrq, coreNmi, irqOut;
    int          errors = 0;
    int          samples_checked = 0;
    always #2.5 ref_clk = ~ref_clk;
    mispr_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irqReq(irqReq), .nmiReq(nmiReq),
        .coreGlobalEn(coreGlobalEn), .coreAck(coreAck), .coreIrq(coreIrq), .coreNmi(coreNmi),
        .ackVector(ackVector), .irqOut(irqOut));
    mispr_core_model core (.ref_clk(ref_clk), .rst_b(rst_b), .coreIrq(coreIrq), .ackGo(ackGo),
        .slow(slow), .reEn(reEn), .coreGlobalEn(coreGlobalEn), .coreAck(coreAck));
    // ==========================================================
    // Compare, bus and handshake tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One word transfer; assumes no wait count, only the watchdog ends a stall
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            @(posedge ref_clk);
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            @(posedge ref_clk);
        end
        rdv = hrdata;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 32'h0);
        check(what, exp, rdv);
    endtask
    task automatic wait_ack(input logic [31:0] exp, input string what);
        while (coreAck !== 1'b1) begin
            @(posedge ref_clk);
        end
        @(posedge ref_clk);
        check(what, exp, 32'(ackVector));
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Watchdog: the sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        conclude();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        rdc(mispr_pkg::IDX_ENABLE_LOW, 32'hffff, "enable low");
        rdc(mispr_pkg::IDX_ENABLE_HIGH, 32'hffff, "enable high");
        rdc(mispr_pkg::IDX_EVT_MASK, 32'h0, "event mask");
        rdc(mispr_pkg::IDX_VECTOR, 32'h10, "idle vector");
        rdc(8'hff, 32'h0, "unmapped");
        // Raw status with every source disabled, reserved lines driven too
        bus(1'b1, mispr_pkg::IDX_ENABLE_LOW, 32'h0);
        bus(1'b1, mispr_pkg::IDX_ENABLE_HIGH, 32'h0);
        irqReq <= 32'ha5b9_5a4b;
        repeat (3) @(posedge ref_clk);
        rdc(mispr_pkg::IDX_STATUS_LOW, 32'h5a4a, "status low");
        rdc(mispr_pkg::IDX_STATUS_HIGH, 32'ha5b1, "status high");
        rdc(mispr_pkg::IDX_VECTOR, 32'h10, "disabled vector");
        bus(1'b1, mispr_pkg::IDX_STATUS_LOW, 32'h0);
        rdc(mispr_pkg::IDX_STATUS_LOW, 32'h5a4a, "status read only");
        // Sources 31 down to 1 each as the top one of a run of active requests
        bus(1'b1, mispr_pkg::IDX_ENABLE_LOW, 32'hffff);
        bus(1'b1, mispr_pkg::IDX_ENABLE_HIGH, 32'hffff);
        for (int s = 31; s >= 1; s--) begin
            irqReq <= 32'hffff_ffff >> (31 - s);
            repeat (3) @(posedge ref_clk);
            rdc(mispr_pkg::IDX_VECTOR, (s == 19) ? 32'h22 : 32'(32'h10 + s), "priority");
        end
        irqReq <= 32'hffff_ffff;
        bus(1'b1, mispr_pkg::IDX_ENABLE_HIGH, 32'h7fff);
        rdc(mispr_pkg::IDX_VECTOR, 32'h2e, "top disabled");
        bus(1'b1, mispr_pkg::IDX_ENABLE_HIGH, 32'hffff);
        irqReq <= 32'h0;
        repeat (3) @(posedge ref_clk);
        rdc(mispr_pkg::IDX_STATUS_HIGH, 32'h0, "status cleared");
        // Entry, blocking, and a nested entry after re-enable
        bus(1'b1, mispr_pkg::IDX_EVT_MASK, 32'h3);
        irqReq <= 32'h20;
        ackGo <= 1'b1;
        wait_ack(32'h15, "first vector");
        irqReq <= 32'h0100_0020;
        nmiReq <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check("blocked", 32'h0, 32'(coreIrq));
        check("nmi", 32'h1, 32'(coreNmi));
        check("event irq", 32'h1, 32'(irqOut));
        nmiReq <= 1'b0;
        bus(1'b1, mispr_pkg::IDX_ENABLE_LOW, 32'hffdf);
        slow <= 1'b1;
        reEn <= 1'b1;
        @(posedge ref_clk);
        reEn <= 1'b0;
        wait_ack(32'h28, "nested vector");
        irqReq <= 32'h0;
        ackGo <= 1'b0;
        rdc(mispr_pkg::IDX_EVT_STATUS, 32'h1, "event status");
        bus(1'b1, mispr_pkg::IDX_EVT_MASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        check("masked event", 32'h0, 32'(irqOut));
        bus(1'b1, mispr_pkg::IDX_EVT_STATUS, 32'h1);
        rdc(mispr_pkg::IDX_EVT_STATUS, 32'h0, "event cleared");
        // A request that vanishes while the slow core waits leaves the error entry
        irqReq <= 32'h0100_0000;
        ackGo <= 1'b1;
        reEn <= 1'b1;
        @(posedge ref_clk);
        reEn <= 1'b0;
        while (coreIrq !== 1'b1) begin
            @(posedge ref_clk);
        end
        @(posedge ref_clk);
        irqReq <= 32'h0;
        wait_ack(32'h10, "error entry");
        rdc(mispr_pkg::IDX_EVT_STATUS, 32'h3, "spurious event");
        conclude();
    end
endmodule
`default_nettype wire
